// >>> mic_intc.sv
// Implementation choices: the AHB-Lite register port and the register offsets.
`include "mic_params.svh"
`default_nettype none
module mic_intc
(
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic extIrqPinA,
  input wire logic extIrqPinB,
  input wire logic overvoltageEvt,
  input wire logic conversionDoneEvt,
  input wire logic [1:0] timeBaseEvt,
  input wire logic [3:0] timerPeriodMatchEvt,
  input wire logic [3:0] timerCompareMatchEvt,
  input wire logic lowVoltageEvt,
  input wire logic stackFull,
  input wire logic [`MIC_PC_W-1:0] nextPc,
  input wire logic returnFromIrqInstr,
  input wire logic sleepMode,
  output mic_pkg::mic_entry_t entry,
  output logic wakeUp,
  output logic extPinAIrqMode,
  output logic extPinBIrqMode,
  output logic globalIrqEnable
);

  // ahb data phase tracking
  logic dpValid_r, dpWrite_r, rdDone_r, addrAccept, wrEn;
  logic [`MIC_ADDR_W-1:0] dpAddr_r;
  logic [31:0] hrdata_r, rdWord;
  logic [7:0] wrByte;
  logic [3:0] wrF, wrE;

  // interrupt state
  logic [`MIC_NSRC-1:0] topF_r, topE_r, topFWr, topEWr, topF_nxt;
  logic [`MIC_NSRC-1:0] topSet, topClr, pending, winOh;
  logic [3:0] winIdx, edgeSel_r, edgeWr, grpRise;
  logic [3:0] tmrPF_r, tmrAF_r, tmrPE_r, tmrAE_r;
  logic [3:0] tmrPFWr, tmrAFWr, tmrPEWr, tmrAEWr;
  logic [3:0] tmrPF_nxt, tmrAF_nxt;
  logic emi_r, emiWr, emi_nxt, c0Spare;
  logic lvF_r, lvE_r, lvFWr, lvEWr, lvF_nxt;
  logic pinA_r, pinB_r, hitA, hitB, takeNow, wakeUp_r;
  logic [1:0] tmrSpare;
  logic [2:0] lvSpare;
  logic [`MIC_NSRC+8:0] allOld, allNew;
  mic_pkg::mic_state_t state_r;
  mic_pkg::mic_entry_t entry_r, entry_nxt;

  // edge match for one pin under its select code
  function automatic logic edgeHit(
    input logic [1:0] sel,
    input logic cur,
    input logic prev
  );
    logic rise;
    logic fall;
    rise = cur & ~prev;
    fall = ~cur & prev;
    case (sel)
      `MIC_EDGE_RISE: edgeHit = rise;
      `MIC_EDGE_FALL: edgeHit = fall;
      `MIC_EDGE_BOTH: edgeHit = rise | fall;
      default: edgeHit = 1'b0;
    endcase
  endfunction

  // bus decode
  assign addrAccept = hsel & htrans[`MIC_HTRANS_ACT] & hready;
  assign wrEn = dpValid_r & dpWrite_r;
  assign wrByte = hwdata[7:0];
  assign wrF = wrByte[`MIC_F_LSB +: 4];
  assign wrE = wrByte[`MIC_E_LSB +: 4];
  assign hreadyout = ~(dpValid_r & ~dpWrite_r & ~rdDone_r);
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  // register read mux; reserved bits read zero
  always_comb
  begin
    rdWord = 32'h0000_0000;
    case (dpAddr_r)
      `MIC_OFS_EDGE: rdWord[7:0] = {4'h0, edgeSel_r};
      `MIC_OFS_C0: rdWord[7:0] = {1'b0, topF_r[`MIC_SRC_G0],
        topF_r[`MIC_SRC_OVP], topF_r[`MIC_SRC_EXTA],
        topE_r[`MIC_SRC_G0], topE_r[`MIC_SRC_OVP],
        topE_r[`MIC_SRC_EXTA], emi_r};
      `MIC_OFS_C1: rdWord[7:0] = {topF_r[`MIC_SRC_G4],
        topF_r[`MIC_SRC_G3], topF_r[`MIC_SRC_G2],
        topF_r[`MIC_SRC_G1], topE_r[`MIC_SRC_G4],
        topE_r[`MIC_SRC_G3], topE_r[`MIC_SRC_G2],
        topE_r[`MIC_SRC_G1]};
      `MIC_OFS_C2: rdWord[7:0] = {topF_r[`MIC_SRC_EXTB],
        topF_r[`MIC_SRC_TB1], topF_r[`MIC_SRC_TB0],
        topF_r[`MIC_SRC_ADC], topE_r[`MIC_SRC_EXTB],
        topE_r[`MIC_SRC_TB1], topE_r[`MIC_SRC_TB0],
        topE_r[`MIC_SRC_ADC]};
      `MIC_OFS_TMR0: rdWord[7:0] = {2'b00, tmrAF_r[0], tmrPF_r[0],
        2'b00, tmrAE_r[0], tmrPE_r[0]};
      `MIC_OFS_TMR1: rdWord[7:0] = {2'b00, tmrAF_r[1], tmrPF_r[1],
        2'b00, tmrAE_r[1], tmrPE_r[1]};
      `MIC_OFS_TMR2: rdWord[7:0] = {2'b00, tmrAF_r[2], tmrPF_r[2],
        2'b00, tmrAE_r[2], tmrPE_r[2]};
      `MIC_OFS_TMR3: rdWord[7:0] = {2'b00, tmrAF_r[3], tmrPF_r[3],
        2'b00, tmrAE_r[3], tmrPE_r[3]};
      `MIC_OFS_LVS: rdWord[7:0] = {3'b000, lvF_r, 3'b000, lvE_r};
      default: rdWord = 32'h0000_0000;
    endcase
  end

  // software write view of every register field
  always_comb
  begin
    topFWr = topF_r;
    topEWr = topE_r;
    emiWr = emi_r;
    edgeWr = edgeSel_r;
    tmrPFWr = tmrPF_r;
    tmrAFWr = tmrAF_r;
    tmrPEWr = tmrPE_r;
    tmrAEWr = tmrAE_r;
    lvFWr = lvF_r;
    lvEWr = lvE_r;
    c0Spare = 1'b0;
    tmrSpare = 2'b00;
    lvSpare = 3'b000;
    if (wrEn)
    begin
      case (dpAddr_r)
        `MIC_OFS_EDGE: edgeWr = wrE;
        `MIC_OFS_C0:
        begin
          {c0Spare, topFWr[`MIC_SRC_G0], topFWr[`MIC_SRC_OVP],
            topFWr[`MIC_SRC_EXTA]} = wrF;
          {topEWr[`MIC_SRC_G0], topEWr[`MIC_SRC_OVP],
            topEWr[`MIC_SRC_EXTA], emiWr} = wrE;
        end
        `MIC_OFS_C1:
        begin
          {topFWr[`MIC_SRC_G4], topFWr[`MIC_SRC_G3],
            topFWr[`MIC_SRC_G2], topFWr[`MIC_SRC_G1]} = wrF;
          {topEWr[`MIC_SRC_G4], topEWr[`MIC_SRC_G3],
            topEWr[`MIC_SRC_G2], topEWr[`MIC_SRC_G1]} = wrE;
        end
        `MIC_OFS_C2:
        begin
          {topFWr[`MIC_SRC_EXTB], topFWr[`MIC_SRC_TB1],
            topFWr[`MIC_SRC_TB0], topFWr[`MIC_SRC_ADC]} = wrF;
          {topEWr[`MIC_SRC_EXTB], topEWr[`MIC_SRC_TB1],
            topEWr[`MIC_SRC_TB0], topEWr[`MIC_SRC_ADC]} = wrE;
        end
        `MIC_OFS_TMR0:
        begin
          {tmrSpare, tmrAFWr[0], tmrPFWr[0]} = wrF;
          {tmrSpare, tmrAEWr[0], tmrPEWr[0]} = wrE;
        end
        `MIC_OFS_TMR1:
        begin
          {tmrSpare, tmrAFWr[1], tmrPFWr[1]} = wrF;
          {tmrSpare, tmrAEWr[1], tmrPEWr[1]} = wrE;
        end
        `MIC_OFS_TMR2:
        begin
          {tmrSpare, tmrAFWr[2], tmrPFWr[2]} = wrF;
          {tmrSpare, tmrAEWr[2], tmrPEWr[2]} = wrE;
        end
        `MIC_OFS_TMR3:
        begin
          {tmrSpare, tmrAFWr[3], tmrPFWr[3]} = wrF;
          {tmrSpare, tmrAEWr[3], tmrPEWr[3]} = wrE;
        end
        `MIC_OFS_LVS:
        begin
          {lvSpare, lvFWr} = wrF;
          {lvSpare, lvEWr} = wrE;
        end
        default: c0Spare = 1'b0;
      endcase
    end
  end

  // external pins act only while their enable is set
  assign hitA = topE_r[`MIC_SRC_EXTA] &
    edgeHit(edgeSel_r[1:0], extIrqPinA, pinA_r);
  assign hitB = topE_r[`MIC_SRC_EXTB] &
    edgeHit(edgeSel_r[3:2], extIrqPinB, pinB_r);
  assign extPinAIrqMode = topE_r[`MIC_SRC_EXTA];
  assign extPinBIrqMode = topE_r[`MIC_SRC_EXTB];

  // member flags: events win over software writes
  assign tmrPF_nxt = tmrPFWr | timerPeriodMatchEvt;
  assign tmrAF_nxt = tmrAFWr | timerCompareMatchEvt;
  assign lvF_nxt = lvFWr | lowVoltageEvt;

  // group flag sets on an enabled member flag rising
  assign grpRise = ((tmrPF_nxt & ~tmrPF_r) & tmrPE_r) |
    ((tmrAF_nxt & ~tmrAF_r) & tmrAE_r);

  // hardware sets of top-level flags
  always_comb
  begin
    topSet = '0;
    topSet[`MIC_SRC_EXTA] = hitA;
    topSet[`MIC_SRC_EXTB] = hitB;
    topSet[`MIC_SRC_OVP] = overvoltageEvt;
    topSet[`MIC_SRC_ADC] = conversionDoneEvt;
    topSet[`MIC_SRC_TB0] = timeBaseEvt[0];
    topSet[`MIC_SRC_TB1] = timeBaseEvt[1];
    topSet[`MIC_SRC_G0] = grpRise[0];
    topSet[`MIC_SRC_G1] = grpRise[1];
    topSet[`MIC_SRC_G2] = grpRise[2];
    topSet[`MIC_SRC_G3] = grpRise[3];
    topSet[`MIC_SRC_G4] = lvF_nxt & ~lvF_r & lvE_r;
  end

  // pending requests need flag and own enable
  assign pending = topF_r & topE_r;

  // fixed priority: lowest index wins
  always_comb
  begin
    winOh = '0;
    winIdx = 4'h0;
    for (int i = `MIC_NSRC - 1; i >= 0; i--)
    begin
      if (pending[i])
      begin
        winOh = '0;
        winOh[i] = 1'b1;
        winIdx = 4'(i);
      end
    end
  end

  // entry allowed only with global enable and room on the stack
  assign takeNow = emi_r & ~stackFull & (|pending) &
    (state_r == mic_pkg::ST_RUN);

  // service clears the winning top-level flag only
  assign topClr = takeNow ? winOh : '0;
  assign topF_nxt = (topFWr & ~topClr) | topSet;

  // global enable: entry clears, return-from-irq sets
  always_comb
  begin
    emi_nxt = emiWr;
    if (returnFromIrqInstr)
      emi_nxt = 1'b1;
    if (takeNow)
      emi_nxt = 1'b0;
  end

  // one-cycle actions towards the core
  always_comb
  begin
    entry_nxt = '0;
    entry_nxt.pop = returnFromIrqInstr;
    if (takeNow)
    begin
      entry_nxt.push = 1'b1;
      entry_nxt.pushPc = nextPc;
      entry_nxt.load = 1'b1;
      entry_nxt.vector = `MIC_PC_W'((winIdx + 4'h1) *
        `MIC_VEC_STEP);
    end
  end

  // wake-up on any flag rising, independent of enables
  assign allOld = {topF_r, tmrPF_r, tmrAF_r, lvF_r};
  assign allNew = {topF_nxt, tmrPF_nxt, tmrAF_nxt, lvF_nxt};
  assign wakeUp = wakeUp_r;
  assign entry = entry_r;
  assign globalIrqEnable = emi_r;

  // bus state
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dpValid_r <= 1'b0;
      dpWrite_r <= 1'b0;
      dpAddr_r <= '0;
      rdDone_r <= 1'b0;
      hrdata_r <= 32'h0000_0000;
    end
    else
    begin
      if (hreadyout)
      begin
        dpValid_r <= addrAccept;
        dpWrite_r <= hwrite;
        dpAddr_r <= haddr[`MIC_ADDR_W-1:0];
      end
      rdDone_r <= dpValid_r & ~dpWrite_r & ~rdDone_r;
      if (dpValid_r & ~dpWrite_r & ~rdDone_r)
        hrdata_r <= rdWord;
    end
  end

  // interrupt registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      topF_r <= '0;
      topE_r <= '0;
      emi_r <= 1'b0;
      edgeSel_r <= {2{`MIC_EDGE_OFF}};
      tmrPF_r <= '0;
      tmrAF_r <= '0;
      tmrPE_r <= '0;
      tmrAE_r <= '0;
      lvF_r <= 1'b0;
      lvE_r <= 1'b0;
    end
    else
    begin
      topF_r <= topF_nxt;
      topE_r <= topEWr;
      emi_r <= emi_nxt;
      edgeSel_r <= edgeWr;
      tmrPF_r <= tmrPF_nxt;
      tmrAF_r <= tmrAF_nxt;
      tmrPE_r <= tmrPEWr;
      tmrAE_r <= tmrAEWr;
      lvF_r <= lvF_nxt;
      lvE_r <= lvEWr;
    end
  end

  // pin history, sequencer and core outputs
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pinA_r <= 1'b0;
      pinB_r <= 1'b0;
      state_r <= mic_pkg::ST_RUN;
      entry_r <= '0;
      wakeUp_r <= 1'b0;
    end
    else
    begin
      pinA_r <= extIrqPinA;
      pinB_r <= extIrqPinB;
      entry_r <= entry_nxt;
      wakeUp_r <= sleepMode & (|(allNew & ~allOld));
      case (state_r)
        mic_pkg::ST_RUN:
          state_r <= takeNow ? mic_pkg::ST_ENTRY : mic_pkg::ST_RUN;
        mic_pkg::ST_ENTRY:
          state_r <= mic_pkg::ST_RUN;
        default:
          state_r <= mic_pkg::ST_RUN;
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> mic_params.svh
`ifndef MIC_PARAMS_SVH
`define MIC_PARAMS_SVH

// program counter width seen by the core
`define MIC_PC_W 12
// register byte offsets (low address bits decoded)
`define MIC_ADDR_W 8
`define MIC_OFS_EDGE 8'h00
`define MIC_OFS_C0 8'h04
`define MIC_OFS_C1 8'h08
`define MIC_OFS_C2 8'h0c
`define MIC_OFS_TMR0 8'h10
`define MIC_OFS_TMR1 8'h14
`define MIC_OFS_TMR2 8'h18
`define MIC_OFS_TMR3 8'h1c
`define MIC_OFS_LVS 8'h20
// nibble layout of flag / enable fields
`define MIC_F_LSB 4
`define MIC_E_LSB 0
// edge select codes
`define MIC_EDGE_OFF 2'b00
`define MIC_EDGE_RISE 2'b01
`define MIC_EDGE_FALL 2'b10
`define MIC_EDGE_BOTH 2'b11
// source indices, ascending vector = descending priority
`define MIC_NSRC 11
`define MIC_SRC_EXTA 0
`define MIC_SRC_OVP 1
`define MIC_SRC_G0 2
`define MIC_SRC_G1 3
`define MIC_SRC_G2 4
`define MIC_SRC_G3 5
`define MIC_SRC_ADC 6
`define MIC_SRC_TB0 7
`define MIC_SRC_TB1 8
`define MIC_SRC_G4 9
`define MIC_SRC_EXTB 10
// vector of source i is (i + 1) * step
`define MIC_VEC_STEP 12'h004
// ahb constants
`define MIC_HTRANS_ACT 1
`define MIC_RST_BYTE 8'h00

`endif

// >>> mic_pkg.sv
`include "mic_params.svh"
`default_nettype none
package mic_pkg;
  typedef enum logic [1:0]
  {
    ST_RUN = 2'b01,
    ST_ENTRY = 2'b10
  } mic_state_t;

  // one-cycle entry / return actions towards the core
  typedef struct packed {
    logic push;
    logic [`MIC_PC_W-1:0] pushPc;
    logic load;
    logic [`MIC_PC_W-1:0] vector;
    logic pop;
  } mic_entry_t;
endpackage
`default_nettype wire

// >>> mic_intc_props.sv
`include "mic_params.svh"
`default_nettype none
module mic_intc_props
(
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic stackFull,
  input wire logic [`MIC_PC_W-1:0] nextPc,
  input wire logic returnFromIrqInstr,
  input wire logic sleepMode,
  input wire mic_pkg::mic_entry_t entry,
  input wire logic wakeUp,
  input wire logic globalIrqEnable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // entry needs global enable and room on the stack
  property p_takeCause;
    entry.load |-> $past(globalIrqEnable) && !$past(stackFull);
  endproperty
  a_takeCause: assert property (p_takeCause)
    else $error("entry without enable or with full stack");
  property p_pushPc;
    entry.push |-> entry.load && entry.pushPc == $past(nextPc);
  endproperty
  a_pushPc: assert property (p_pushPc)
    else $error("pushed pc or load pairing wrong");
  property p_gieOff;
    entry.load |-> !globalIrqEnable ##1 !entry.load;
  endproperty
  a_gieOff: assert property (p_gieOff)
    else $error("global enable kept or second entry");
  property p_pop;
    returnFromIrqInstr |=> entry.pop;
  endproperty
  a_pop: assert property (p_pop)
    else $error("no pop after return");
  property p_return_from_irq_instr;
    returnFromIrqInstr |=> globalIrqEnable || entry.load;
  endproperty
  a_return_from_irq_instr: assert property (p_return_from_irq_instr)
    else $error("return did not restore global enable");
  property p_vecRange;
    entry.load |-> entry.vector[1:0] == 2'b00 && entry.vector >= 12'h004
      && entry.vector <= 12'h02c;
  endproperty
  a_vecRange: assert property (p_vecRange)
    else $error("vector outside table");
  property p_wake;
    wakeUp |-> $past(sleepMode);
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake pulse outside sleep");
  property p_readWait;
    hsel && htrans[1] && !hwrite && hready |=> !hreadyout ##1 hreadyout;
  endproperty
  a_readWait: assert property (p_readWait)
    else $error("read data phase timing wrong");
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay)
    else $error("response not okay");

  // main scenarios reached
  c_take: cover property (entry.load);
  c_pop: cover property (entry.pop);
  c_wake: cover property (wakeUp);
endmodule
`default_nettype wire

// >>> mic_core_model.sv
`include "mic_params.svh"
`default_nettype none
module mic_core_model
#(
  parameter int DEPTH = 1
)
(
  input wire logic clk,
  input wire logic rst,
  input wire mic_pkg::mic_entry_t entry,
  input wire logic retReq,
  output logic stackFull,
  output logic [`MIC_PC_W-1:0] nextPc,
  output logic returnFromIrqInstr
);
  logic [`MIC_PC_W-1:0] stack [DEPTH];
  int depth;

  // defined values before the first edge
  initial
  begin
    depth = 0;
    nextPc = 12'h100;
    returnFromIrqInstr = 1'b0;
  end

  // full once every slot holds a return address
  assign stackFull = (depth == DEPTH);

  // pc walk: push on entry, pop on return
  always @(posedge clk)
  begin
    returnFromIrqInstr <= retReq && !rst;
    if (rst)
    begin
      depth <= 0;
      nextPc <= 12'h100;
    end
    else if (entry.push)
    begin
      stack[depth] <= entry.pushPc;
      depth <= depth + 1;
      nextPc <= entry.vector;
    end
    else if (entry.pop)
    begin
      depth <= depth - 1;
      nextPc <= stack[depth - 1];
    end
    else
      nextPc <= nextPc + 12'h001;
  end
endmodule
`default_nettype wire

// >>> test_mcu_interrupt_controller.sv
`include "mic_params.svh"
`default_nettype none
module test_mcu_interrupt_controller;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, stackFull, returnFromIrqInstr, wakeUp;
  logic [31:0] hrdata, rdLat;
  logic extIrqPinA = 1'b0;
  logic extIrqPinB = 1'b0;
  logic [1:0] timeBaseEvt = 2'h0;
  logic [3:0] timerPeriodMatchEvt = 4'h0;
  logic overvoltageEvt = 1'b0;
  logic conversionDoneEvt = 1'b0;
  logic [3:0] timerCompareMatchEvt = 4'h0;
  logic lowVoltageEvt = 1'b0;
  logic sleepMode = 1'b0;
  logic retReq = 1'b0;
  logic globalIrqEnable, extPinAIrqMode, extPinBIrqMode;
  logic [`MIC_PC_W-1:0] nextPc;
  mic_pkg::mic_entry_t entry;
  int mismatches = 0;
  int comparisons = 0;
  int wakeCount = 0;

  mic_intc u_dut
  (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .extIrqPinA(extIrqPinA), .extIrqPinB(extIrqPinB),
    .overvoltageEvt(overvoltageEvt), .conversionDoneEvt(conversionDoneEvt),
    .timeBaseEvt(timeBaseEvt), .timerPeriodMatchEvt(timerPeriodMatchEvt),
    .timerCompareMatchEvt(timerCompareMatchEvt),
    .lowVoltageEvt(lowVoltageEvt), .stackFull(stackFull), .nextPc(nextPc),
    .returnFromIrqInstr(returnFromIrqInstr), .sleepMode(sleepMode),
    .entry(entry), .wakeUp(wakeUp), .extPinAIrqMode(extPinAIrqMode),
    .extPinBIrqMode(extPinBIrqMode), .globalIrqEnable(globalIrqEnable)
  );

  mic_core_model #(.DEPTH(1)) u_core
  (
    .clk(clk), .rst(rst), .entry(entry), .retReq(retReq),
    .stackFull(stackFull), .nextPc(nextPc),
    .returnFromIrqInstr(returnFromIrqInstr)
  );

  // clock and wake pulse counter
  initial
  begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (wakeUp === 1'b1)
      wakeCount++;
  end

  task automatic final_report(input bit hung);
    if (hung)
      mismatches++;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // hready seen before the edge, read data taken with it
  task automatic waitReady();
    int n;
    n = 0;
    @(negedge clk);
    while (hready_ok() == 1'b0)
    begin
      n++;
      if (n > 40)
        final_report(1'b1);
      @(negedge clk);
    end
    rdLat = hrdata;
    @(posedge clk);
  endtask

  function automatic bit hready_ok();
    return hreadyout === 1'b1;
  endfunction

  task automatic busXfer(input logic wr, input logic [7:0] a,
    input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    waitReady();
    htrans <= 2'h0;
    hwdata <= wd;
    waitReady();
  endtask

  task automatic busWr(input logic [7:0] a, input logic [31:0] d);
    busXfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    busXfer(1'b0, a, 32'h0);
    check(rdLat, exp);
  endtask

  task automatic waitTake(input logic [11:0] vec);
    int n;
    n = 0;
    @(negedge clk);
    while (entry.load !== 1'b1)
    begin
      n++;
      if (n > 20)
        final_report(1'b1);
      @(negedge clk);
    end
    check({20'h0, entry.vector}, {20'h0, vec});
    @(posedge clk);
  endtask

  task automatic noTake(input int n);
    repeat (n)
    begin
      @(negedge clk);
      check({31'h0, entry.load}, 32'h0);
    end
    @(posedge clk);
  endtask

  task automatic ret();
    retReq <= 1'b1;
    cyc(1);
    retReq <= 1'b0;
    cyc(1);
  endtask

  task automatic t_regs();
    rd(8'h20, 32'h0);
    busWr(8'h20, 32'hff);
    rd(8'h20, 32'h11);
    busWr(8'h20, 32'h00);
    rd(8'h40, 32'h0);
    $display("register test done");
  endtask

  task automatic t_edges();
    logic [1:0] code;
    busWr(8'h04, 32'h02);
    @(negedge clk);
    check({31'h0, extPinAIrqMode}, 32'h1);
    @(posedge clk);
    // pin b: ignored while disabled, flags on rising once enabled
    busWr(8'h00, 32'h04);
    extIrqPinB <= 1'b1;
    cyc(3);
    extIrqPinB <= 1'b0;
    rd(8'h0c, 32'h00);
    busWr(8'h0c, 32'h08);
    extIrqPinB <= 1'b1;
    @(negedge clk);
    check({31'h0, extPinBIrqMode}, 32'h1);
    cyc(3);
    rd(8'h0c, 32'h88);
    busWr(8'h0c, 32'h00);
    extIrqPinB <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      code = i[1:0];
      busWr(8'h00, {30'h0, code});
      busWr(8'h04, 32'h02);
      extIrqPinA <= 1'b1;
      cyc(3);
      rd(8'h04, code[0] ? 32'h12 : 32'h02);
      busWr(8'h04, 32'h02);
      extIrqPinA <= 1'b0;
      cyc(3);
      rd(8'h04, code[1] ? 32'h12 : 32'h02);
    end
    $display("edge select test done");
  endtask

  task automatic t_take();
    busWr(8'h00, 32'h01);
    busWr(8'h04, 32'h06);
    overvoltageEvt <= 1'b1;
    extIrqPinA <= 1'b1;
    cyc(1);
    overvoltageEvt <= 1'b0;
    noTake(4);
    rd(8'h04, 32'h36);
    busWr(8'h04, 32'h37);
    waitTake(12'h004);
    rd(8'h04, 32'h26);
    ret();
    waitTake(12'h008);
    rd(8'h04, 32'h06);
    ret();
    $display("priority test done");
  endtask

  task automatic t_group();
    busWr(8'h0c, 32'h01);
    conversionDoneEvt <= 1'b1;
    cyc(1);
    conversionDoneEvt <= 1'b0;
    waitTake(12'h01c);
    rd(8'h0c, 32'h01);
    busWr(8'h10, 32'h02);
    busWr(8'h04, 32'h09);
    timerCompareMatchEvt <= 4'h1;
    cyc(1);
    timerCompareMatchEvt <= 4'h0;
    noTake(6);
    rd(8'h04, 32'h49);
    ret();
    waitTake(12'h00c);
    rd(8'h10, 32'h22);
    rd(8'h04, 32'h08);
    ret();
    $display("group test done");
  endtask

  task automatic t_sleep();
    sleepMode <= 1'b1;
    wakeCount = 0;
    repeat (2)
    begin
      lowVoltageEvt <= 1'b1;
      cyc(1);
      lowVoltageEvt <= 1'b0;
      cyc(4);
      check(32'(wakeCount), 32'h1);
    end
    noTake(2);
    rd(8'h20, 32'h10);
    sleepMode <= 1'b0;
    // time base and period match flags set with enables low
    timeBaseEvt <= 2'h1;
    timerPeriodMatchEvt <= 4'h2;
    cyc(1);
    timeBaseEvt <= 2'h0;
    timerPeriodMatchEvt <= 4'h0;
    rd(8'h0c, 32'h21);
    rd(8'h14, 32'h10);
    $display("wake test done");
  endtask

  // reset, then the scenarios in turn
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_edges();
    t_take();
    t_group();
    t_sleep();
    final_report(1'b0);
  end
endmodule

bind mic_intc mic_intc_props u_props
(
  .clk(clk), .rst(rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .stackFull(stackFull), .nextPc(nextPc),
  .returnFromIrqInstr(returnFromIrqInstr), .sleepMode(sleepMode),
  .entry(entry), .wakeUp(wakeUp), .globalIrqEnable(globalIrqEnable)
);
`default_nettype wire
